// [include/pin_mux_pkg.sv]
package pin_mux_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] PF_DIR_OFS = 8'h00;
  localparam logic [7:0] PF_FUNC_OFS = 8'h04;
  localparam logic [7:0] PG_DIR_OFS = 8'h08;
  localparam logic [7:0] PIN_STATE_OFS = 8'h0C;
  // writable bits; everything else stores and reads zero
  localparam logic [15:0] PF_DIR_MASK = 16'h00EE;
  localparam logic [15:0] PF_FUNC_MASK = 16'hFCFC;
  localparam logic [15:0] PG_DIR_MASK = 16'hE000;
  // reset values
  localparam logic [15:0] PF_DIR_RESET = 16'h0000;
  localparam logic [15:0] PF_FUNC_RESET = 16'h0000;
  localparam logic [15:0] PG_DIR_RESET = 16'h0000;
  // function field positions (two bits each)
  localparam int PF7_FUNC_POS = 14;
  localparam int PF6_FUNC_POS = 12;
  localparam int PF5_FUNC_POS = 10;
  localparam int PF3_FUNC_POS = 6;
  localparam int PF2_FUNC_POS = 4;
  localparam int PF1_FUNC_POS = 2;
  // lowest port g direction bit (pin 29), pins 30 and 31 follow
  localparam int PG_DIR_POS = 13;
  // pin state register layout
  localparam int STATE_PF_OE_POS = 0;
  localparam int STATE_PG_OE_POS = 8;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // register selector codes
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_PF_DIR = 3'b001,
    SEL_PF_FUNC = 3'b010,
    SEL_PG_DIR = 3'b011,
    SEL_PIN_STATE = 3'b100
  } reg_sel_t;
  // pin function codes
  typedef enum logic [1:0] {
    FUNC_GPIO = 2'b00,
    FUNC_ALT1 = 2'b01,
    FUNC_ALT2 = 2'b10,
    FUNC_ALT3 = 2'b11
  } pin_func_t;
  // axi channel state
  typedef enum logic {
    CH_IDLE = 1'b0,
    CH_RESP = 1'b1
  } chan_state_t;
endpackage : pin_mux_pkg

// [include/reg_access_if.sv]
`timescale 1ns/1ps
`default_nettype none
// register access between bus slave and register file
interface reg_access_if import pin_mux_pkg::*; ();
  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  modport bus (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
               input wr_ok, rd_data, rd_ok);
  modport regs (input wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface : reg_access_if
`default_nettype wire

// [design/pad_stage.sv]
`timescale 1ns/1ps
`default_nettype none
// output flops for a group of pins, plus capture of the pin levels
module pad_stage #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // next drive from the mux
  input wire logic [N-1:0] next_out,
  input wire logic [N-1:0] next_oe,
  // pin levels
  input wire logic [N-1:0] pin_in,
  // registered pad side
  output logic [N-1:0] out,
  output logic [N-1:0] oe,
  output logic [N-1:0] in_q
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // each pin starts undriven so nothing fights a board driver
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          out[i] <= 1'b0;
          oe[i] <= 1'b0;
          in_q[i] <= 1'b0;
        end else begin
          out[i] <= next_out[i];
          oe[i] <= next_oe[i];
          in_q[i] <= pin_in[i];
        end
      end
    end
  endgenerate
endmodule : pad_stage
`default_nettype wire

// [design/axil_slave.sv]
`timescale 1ns/1ps
`default_nettype none
// axi4-lite slave front end; one write and one read in flight
module axil_slave import pin_mux_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register file side
  reg_access_if.bus rif
);
  chan_state_t wr_state, next_wr_state; // write channel state
  chan_state_t rd_state, next_rd_state; // read channel state
  logic aw_held, next_aw_held; // address captured
  logic w_held, next_w_held; // data captured
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [DATA_W-1:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic [DATA_W-1:0] next_rdata;
  logic next_awready, next_wready, next_arready, next_bvalid, next_rvalid;

  // address and data may arrive in either order; the write fires once both are held
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_wr_state = wr_state;
    next_bresp = bresp;
    next_rd_state = rd_state;
    next_rdata = rdata;
    next_rresp = rresp;
    rif.wr_stb = aw_held && w_held && (wr_state == CH_IDLE);
    rif.wr_addr = aw_addr;
    rif.wr_data = w_data;
    rif.wr_strb = w_strb;
    rif.rd_addr = araddr;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    case (wr_state)
      CH_IDLE: begin
        // unmapped addresses still answer, with an error
        if (rif.wr_stb) begin
          next_wr_state = CH_RESP;
          next_bresp = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
        end
      end
      default: begin
        if (bready) begin
          next_wr_state = CH_IDLE;
        end
      end
    endcase
    case (rd_state)
      CH_IDLE: begin
        // read data is sampled on the address handshake edge
        if (arvalid && arready) begin
          next_rd_state = CH_RESP;
          next_rdata = rif.rd_data;
          next_rresp = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
      end
      default: begin
        if (rready) begin
          next_rd_state = CH_IDLE;
        end
      end
    endcase
    // readies close while a response is pending so nothing queues up
    next_awready = !next_aw_held && (next_wr_state == CH_IDLE);
    next_wready = !next_w_held && (next_wr_state == CH_IDLE);
    next_bvalid = (next_wr_state == CH_RESP);
    next_arready = (next_rd_state == CH_IDLE);
    next_rvalid = (next_rd_state == CH_RESP);
  end

  // channel registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_state <= CH_IDLE;
      rd_state <= CH_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
      bresp <= RESP_OKAY;
      rresp <= RESP_OKAY;
      rdata <= '0;
      awready <= 1'b1;
      wready <= 1'b1;
      arready <= 1'b1;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= next_bresp;
      rresp <= next_rresp;
      rdata <= next_rdata;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
    end
  end
endmodule : axil_slave
`default_nettype wire

// [design/port_f_g_pin_function_direction.sv]
`timescale 1ns/1ps
`default_nettype none
module port_f_g_pin_function_direction import pin_mux_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // operating mode and port g selection from outside
  input wire logic single_chip,
  input wire logic [2:0] pg_func_sel,
  // port f pins, index = pin number
  input wire logic [7:0] pf_in,
  output logic [7:0] pf_out,
  output logic [7:0] pf_oe,
  // port g pins, index 0..2 = pin 29..31
  input wire logic [2:0] pg_in,
  output logic [2:0] pg_out,
  output logic [2:0] pg_oe,
  // general i/o data path
  input wire logic [7:0] pf_gpio_out,
  output logic [7:0] pf_gpio_in,
  input wire logic [2:0] pg_gpio_out,
  output logic [2:0] pg_gpio_in,
  // dma controller
  output logic dma_request_ch0,
  output logic dma_request_ch1,
  input wire logic dma_request_sampled_ch0,
  input wire logic dma_request_sampled_ch1,
  input wire logic dma_acknowledge_ch0,
  input wire logic dma_acknowledge_ch1,
  // interrupt controller
  input wire logic interrupt_ack_output,
  // pulse timer unit: 0=0a 1=0b 2=0c 3=0d 4=2a 5=2b
  input wire logic [5:0] timer_out,
  output logic [5:0] timer_in,
  // serial communication unit
  input wire logic serial1_transmit,
  output logic serial1_receive,
  input wire logic serial2_transmit,
  output logic serial2_receive,
  input wire logic serial2_clock_out,
  output logic serial2_clock_in
);
  reg_access_if rif();

  logic [15:0] port_f_low_direction, next_port_f_low_direction;
  logic [15:0] port_f_low_function_select, next_port_f_low_function_select;
  logic [15:0] port_g_direction, next_port_g_direction;
  reg_sel_t wsel, rsel; // decoded write and read targets
  logic [7:0] next_pf_out, next_pf_oe;
  logic [2:0] next_pg_out, next_pg_oe;
  pin_func_t f7, f6, f5, f3, f2, f1; // effective pin functions
  logic next_dma_request_ch0, next_dma_request_ch1;
  logic [5:0] next_timer_in;
  logic next_serial1_receive, next_serial2_receive, next_serial2_clock_in;

  // address to register, shared by write and read paths
  function automatic reg_sel_t reg_select(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:2] == PF_DIR_OFS[ADDR_W-1:2]) begin
      return SEL_PF_DIR;
    end else if (a[ADDR_W-1:2] == PF_FUNC_OFS[ADDR_W-1:2]) begin
      return SEL_PF_FUNC;
    end else if (a[ADDR_W-1:2] == PG_DIR_OFS[ADDR_W-1:2]) begin
      return SEL_PG_DIR;
    end else if (a[ADDR_W-1:2] == PIN_STATE_OFS[ADDR_W-1:2]) begin
      return SEL_PIN_STATE;
    end else begin
      return SEL_NONE;
    end
  endfunction : reg_select

  // byte-lane merge into a 16-bit register, then drop reserved bits
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      v[15:8] = nw[15:8];
    end
    return v & mask;
  endfunction : merge16

  // a field's code, with dma choices falling back to gpio in single-chip mode
  function automatic pin_func_t eff_func(input logic [15:0] r, input int pos,
                                         input logic dma_mode_gated, input logic sc);
    pin_func_t f;
    f = pin_func_t'(r[pos +: 2]);
    if (dma_mode_gated && sc && (f == FUNC_ALT1)) begin
      f = FUNC_GPIO;
    end
    return f;
  endfunction : eff_func

  // bus front end
  axil_slave u_bus (
    .mclk(mclk),
    .reset(reset),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif)
  );

  // register writes and reads; pin state is read-only
  always_comb begin
    wsel = reg_select(rif.wr_addr);
    rsel = reg_select(rif.rd_addr);
    next_port_f_low_direction = port_f_low_direction;
    next_port_f_low_function_select = port_f_low_function_select;
    next_port_g_direction = port_g_direction;
    rif.wr_ok = (wsel != SEL_NONE);
    rif.rd_ok = (rsel != SEL_NONE);
    rif.rd_data = '0;
    if (rif.wr_stb) begin
      if (wsel == SEL_PF_DIR) begin
        next_port_f_low_direction = merge16(port_f_low_direction, rif.wr_data[15:0],
                                            rif.wr_strb[1:0], PF_DIR_MASK);
      end else if (wsel == SEL_PF_FUNC) begin
        // a reserved code 11 is stored as written; the mux leaves such a pin idle
        next_port_f_low_function_select = merge16(port_f_low_function_select,
                                                  rif.wr_data[15:0], rif.wr_strb[1:0],
                                                  PF_FUNC_MASK);
      end else if (wsel == SEL_PG_DIR) begin
        next_port_g_direction = merge16(port_g_direction, rif.wr_data[15:0],
                                        rif.wr_strb[1:0], PG_DIR_MASK);
      end
    end
    if (rsel == SEL_PF_DIR) begin
      rif.rd_data[15:0] = port_f_low_direction;
    end else if (rsel == SEL_PF_FUNC) begin
      rif.rd_data[15:0] = port_f_low_function_select;
    end else if (rsel == SEL_PG_DIR) begin
      rif.rd_data[15:0] = port_g_direction;
    end else if (rsel == SEL_PIN_STATE) begin
      rif.rd_data[STATE_PF_OE_POS +: 8] = pf_oe;
      rif.rd_data[STATE_PG_OE_POS +: 3] = pg_oe;
    end
  end

  // only the external power-on reset reaches these; no other reset exists here
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      port_f_low_direction <= PF_DIR_RESET;
      port_f_low_function_select <= PF_FUNC_RESET;
      port_g_direction <= PG_DIR_RESET;
    end else begin
      port_f_low_direction <= next_port_f_low_direction;
      port_f_low_function_select <= next_port_f_low_function_select;
      port_g_direction <= next_port_g_direction;
    end
  end

  // pin function mux: gpio and timer follow the direction bit, others their function
  always_comb begin
    f7 = eff_func(port_f_low_function_select, PF7_FUNC_POS, 1'b1, single_chip);
    f6 = eff_func(port_f_low_function_select, PF6_FUNC_POS, 1'b1, single_chip);
    f5 = eff_func(port_f_low_function_select, PF5_FUNC_POS, 1'b1, single_chip);
    f3 = eff_func(port_f_low_function_select, PF3_FUNC_POS, 1'b0, single_chip);
    f2 = eff_func(port_f_low_function_select, PF2_FUNC_POS, 1'b0, single_chip);
    f1 = eff_func(port_f_low_function_select, PF1_FUNC_POS, 1'b0, single_chip);
    // default: every pin is gpio steered by its direction bit
    next_pf_out = pf_gpio_out & PF_DIR_MASK[7:0];
    next_pf_oe = port_f_low_direction[7:0];
    next_pg_out = pg_gpio_out;
    next_pg_oe = port_g_direction[PG_DIR_POS +: 3];
    // unselected peripheral inputs sit at idle high, timer inputs low
    next_dma_request_ch0 = 1'b1;
    next_dma_request_ch1 = 1'b1;
    next_timer_in = 6'h00;
    next_serial1_receive = 1'b1;
    next_serial2_receive = 1'b1;
    next_serial2_clock_in = 1'b1;
    case (f7)
      FUNC_ALT1: begin
        next_pf_oe[7] = 1'b0;
        next_dma_request_ch1 = pf_in[7];
      end
      FUNC_ALT2: begin
        next_pf_out[7] = interrupt_ack_output;
        next_pf_oe[7] = 1'b1;
      end
      FUNC_ALT3: begin
        next_pf_out[7] = timer_out[3];
        next_timer_in[3] = pf_in[7];
      end
      default: begin
      end
    endcase
    case (f6)
      FUNC_ALT1: begin
        next_pf_out[6] = dma_request_sampled_ch1;
        next_pf_oe[6] = 1'b1;
      end
      FUNC_ALT2: begin
        next_pf_out[6] = serial1_transmit;
        next_pf_oe[6] = 1'b1;
      end
      FUNC_ALT3: begin
        next_pf_out[6] = timer_out[4];
        next_timer_in[4] = pf_in[6];
      end
      default: begin
      end
    endcase
    case (f5)
      FUNC_ALT1: begin
        next_pf_out[5] = dma_acknowledge_ch1;
        next_pf_oe[5] = 1'b1;
      end
      FUNC_ALT2: begin
        next_pf_oe[5] = 1'b0;
        next_serial1_receive = pf_in[5];
      end
      FUNC_ALT3: begin
        next_pf_out[5] = timer_out[5];
        next_timer_in[5] = pf_in[5];
      end
      default: begin
      end
    endcase
    case (f3)
      FUNC_ALT1: begin
        next_pf_oe[3] = 1'b0;
        next_dma_request_ch0 = pf_in[3];
      end
      FUNC_ALT2: begin
        next_pf_out[3] = timer_out[0];
        next_timer_in[0] = pf_in[3];
      end
      FUNC_ALT3: begin
        next_pf_oe[3] = 1'b0; // reserved code: pin left undriven
      end
      default: begin
      end
    endcase
    case (f2)
      FUNC_ALT1: begin
        next_pf_out[2] = dma_request_sampled_ch0;
        next_pf_oe[2] = 1'b1;
      end
      FUNC_ALT2: begin
        next_pf_out[2] = timer_out[2];
        next_timer_in[2] = pf_in[2];
      end
      FUNC_ALT3: begin
        next_pf_oe[2] = 1'b0;
      end
      default: begin
      end
    endcase
    case (f1)
      FUNC_ALT1: begin
        next_pf_out[1] = dma_acknowledge_ch0;
        next_pf_oe[1] = 1'b1;
      end
      FUNC_ALT2: begin
        next_pf_out[1] = timer_out[1];
        next_timer_in[1] = pf_in[1];
      end
      FUNC_ALT3: begin
        next_pf_oe[1] = 1'b0;
      end
      default: begin
      end
    endcase
    // port g: receive ignores direction, transmit drives, clock keeps direction
    if (pg_func_sel[2]) begin
      next_pg_oe[2] = 1'b0;
      next_serial2_receive = pg_in[2];
    end
    if (pg_func_sel[1]) begin
      next_pg_out[1] = serial2_transmit;
      next_pg_oe[1] = 1'b1;
    end
    if (pg_func_sel[0]) begin
      next_pg_out[0] = serial2_clock_out;
      next_serial2_clock_in = pg_in[0];
    end
  end

  // port f pads
  pad_stage #(.N(8)) u_pf_pads (
    .mclk(mclk),
    .reset(reset),
    .next_out(next_pf_out),
    .next_oe(next_pf_oe),
    .pin_in(pf_in),
    .out(pf_out),
    .oe(pf_oe),
    .in_q(pf_gpio_in)
  );

  // port g pads
  pad_stage #(.N(3)) u_pg_pads (
    .mclk(mclk),
    .reset(reset),
    .next_out(next_pg_out),
    .next_oe(next_pg_oe),
    .pin_in(pg_in),
    .out(pg_out),
    .oe(pg_oe),
    .in_q(pg_gpio_in)
  );

  // peripheral-facing inputs, registered like the pads
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dma_request_ch0 <= 1'b1;
      dma_request_ch1 <= 1'b1;
      timer_in <= 6'h00;
      serial1_receive <= 1'b1;
      serial2_receive <= 1'b1;
      serial2_clock_in <= 1'b1;
    end else begin
      dma_request_ch0 <= next_dma_request_ch0;
      dma_request_ch1 <= next_dma_request_ch1;
      timer_in <= next_timer_in;
      serial1_receive <= next_serial1_receive;
      serial2_receive <= next_serial2_receive;
      serial2_clock_in <= next_serial2_clock_in;
    end
  end
endmodule : port_f_g_pin_function_direction
`default_nettype wire

// [test/pin_mux_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// handshake and pin drive relations watched at the top ports
module pin_mux_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // bus handshakes, grouped to keep the bind short
  input wire logic awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic arvalid, arready, rvalid, rready,
  // pin side
  input wire logic [7:0] pf_oe,
  input wire logic serial1_receive, dma_request_ch0, dma_request_ch1
);
  // one domain, so clock and disable are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  reset_clear_a: assert property ($fell(reset) |-> pf_oe == 8'h00)
    else $error("pins driven right after reset");
  unused_pins_a: assert property (!pf_oe[4] && !pf_oe[0])
    else $error("pin without direction bit driven");
  rx_idle_a: assert property (pf_oe[5] |-> serial1_receive)
    else $error("receive path fed while pin drives");
  dma_request_ch0_idle_a: assert property (pf_oe[3] |-> dma_request_ch0)
    else $error("request 0 fed while pin drives");
  dma_request_ch1_idle_a: assert property (pf_oe[7] |-> dma_request_ch1)
    else $error("request 1 fed while pin drives");
  // bus contract: answer timing and refusal while busy
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered");
  wr_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  wr_release_a: assert property (bvalid && bready |=> !bvalid && awready)
    else $error("write response not released");
  rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read not answered");
  rd_release_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read data not released");
endmodule : pin_mux_sva
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// register access over axi4-lite and pin drive checks at the ports
module testbench import pin_mux_pkg::*;;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  // bus master side
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd_data;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  // pin side; pat keeps peripheral inputs moving
  logic single_chip = 1'b0;
  logic [2:0] pg_func_sel = 3'h0, pg_oe;
  logic [7:0] pf_gpio_out = 8'h00, pf_out, pf_oe, pf_gpio_in;
  logic [5:0] timer_in;
  logic serial1_receive, dma_request_ch0, dma_request_ch1;
  logic [15:0] pat = 16'h0000;
  int err_count = 0;
  int n_checks = 0;

  port_f_g_pin_function_direction i_dut (.mclk(mclk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .single_chip(single_chip), .pg_func_sel(pg_func_sel),
    .pf_in(pat[7:0]), .pf_out(pf_out), .pf_oe(pf_oe), .pg_in(pat[10:8]), .pg_out(),
    .pg_oe(pg_oe), .pf_gpio_out(pf_gpio_out), .pf_gpio_in(pf_gpio_in),
    .pg_gpio_out(pat[13:11]), .pg_gpio_in(), .dma_request_ch0(dma_request_ch0),
    .dma_request_ch1(dma_request_ch1),
    .dma_request_sampled_ch0(pat[0]), .dma_request_sampled_ch1(pat[1]),
    .dma_acknowledge_ch0(pat[2]), .dma_acknowledge_ch1(pat[3]),
    .interrupt_ack_output(pat[4]), .timer_out(pat[5:0]), .timer_in(timer_in),
    .serial1_transmit(pat[6]), .serial1_receive(serial1_receive), .serial2_transmit(pat[7]),
    .serial2_receive(), .serial2_clock_out(pat[8]), .serial2_clock_in());

  // clock and moving pin pattern
  always #50 mclk = ~mclk;
  always @(posedge mclk) pat <= pat + 16'h0001;

  // compare one value, count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge mclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge mclk); // an edge passes before bready can rise again
  endtask : wr

  // read: data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rd_data = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge mclk); // an edge passes before rready can rise again
  endtask : rd

  // load function and direction, let the pin stage follow
  task automatic pins(input logic [15:0] f, input logic [15:0] d);
    wr(PF_FUNC_OFS, {16'h0000, f});
    wr(PF_DIR_OFS, {16'h0000, d});
    repeat (2) @(posedge mclk);
  endtask : pins

  // reset values and writable bits
  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      rd(8'(4 * i));
      chk(rd_data, 32'h0000_0000);
    end
    wr(PF_DIR_OFS, 32'hffff_ffff);
    chk(resp, RESP_OKAY);
    rd(PF_DIR_OFS);
    chk(rd_data, 32'h0000_00ee);
    wr(PG_DIR_OFS, 32'hffff_ffff);
    rd(PG_DIR_OFS);
    chk(rd_data, 32'h0000_e000);
    wr(PF_FUNC_OFS, 32'h0000_fca8);
    rd(PF_FUNC_OFS);
    chk(rd_data, 32'h0000_fca8);
    rd(8'h20);
    chk(resp, RESP_SLVERR);
  endtask : t_regs

  // function codes 00 to 10 on every pin, 11 on pins 7 to 5, against direction and mode: {mode, func, dir, oe}
  task automatic t_func;
    logic [40:0] tbl [8] = '{{1'b0, 16'h0000, 16'h00ee, 8'hee},
      {1'b0, 16'h0000, 16'h0000, 8'h00}, {1'b0, 16'h5454, 16'h0000, 8'h66},
      {1'b1, 16'h5454, 16'h00e0, 8'he6}, {1'b0, 16'ha8a8, 16'h0000, 8'hc0},
      {1'b0, 16'ha8a8, 16'h00ee, 8'hce}, {1'b0, 16'hfca8, 16'h00ee, 8'hee},
      {1'b0, 16'hfca8, 16'h0000, 8'h00}};
    foreach (tbl[i]) begin
      single_chip <= tbl[i][40];
      pins(tbl[i][39:24], tbl[i][23:8]);
      chk(pf_oe, tbl[i][7:0]);
    end
    single_chip <= 1'b0;
  endtask : t_func

  // general output data reaches the driven pins 1-3 and 5-7
  task automatic t_gpio;
    pf_gpio_out <= 8'h5a;
    pins(16'h0000, 16'h00ee);
    chk(pf_out & 8'hee, 8'h4a);
  endtask : t_gpio

  // peripheral paths follow the moving pattern one registered stage late
  task automatic t_route;
    logic [15:0] p;
    pins(16'ha8a8, 16'h0000);
    p = pat;
    @(posedge mclk);
    chk({pf_out[7:6], serial1_receive}, {p[4], p[6], p[5]});
    chk(pf_gpio_in, p[7:0]);
    pins(16'h5454, 16'h0000);
    p = pat;
    @(posedge mclk);
    chk({dma_request_ch1, pf_out[6:5], dma_request_ch0, pf_out[2:1]},
        {p[7], p[1], p[3], p[3], p[0], p[2]});
    pins(16'hfca8, 16'h0000);
    p = pat;
    @(posedge mclk);
    chk(timer_in, {p[5], p[6], p[7], p[2], p[1], p[3]});
  endtask : t_route

  // port g: {select, dir, oe}
  task automatic t_pg;
    logic [21:0] tbl [3] = '{{3'b000, 16'he000, 3'b111},
      {3'b111, 16'h0000, 3'b010}, {3'b111, 16'he000, 3'b011}};
    foreach (tbl[i]) begin
      pg_func_sel <= tbl[i][21:19];
      wr(PG_DIR_OFS, {16'h0000, tbl[i][18:3]});
      repeat (2) @(posedge mclk);
      chk(pg_oe, tbl[i][2:0]);
    end
  endtask : t_pg

  // second reset in mid-run clears the registers and the port f drive
  task automatic t_reset;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      rd(8'(4 * i));
      chk(rd_data, 32'h0000_0000);
    end
    chk(pf_oe, 8'h00);
  endtask : t_reset

  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_func();
    t_route();
    t_gpio();
    t_pg();
    t_reset();
    results();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    results();
  end
endmodule : testbench

bind port_f_g_pin_function_direction pin_mux_sva i_sva (.mclk(mclk), .reset(reset),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .pf_oe(pf_oe), .serial1_receive(serial1_receive), .dma_request_ch0(dma_request_ch0),
  .dma_request_ch1(dma_request_ch1));
`default_nettype wire
